// ---- src/comm_watch.sv ----
// Purpose: Consecutive link error counter and link timeout for the serial master link.
// Assumes: Error and good-frame strobes are one-cycle pulses.
// Notes: A zero threshold or zero timeout disables that check.
`include "motor_alarm_regs.svh"
module comm_watch #(
    parameter int TICK = `TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic errPulse,
    input wire logic okPulse,
    input wire logic [7:0] threshold,
    input wire logic [15:0] timeoutMs,
    output logic errHit,
    output logic toutHit
);
    import motor_alarm_pkg::*;
    logic [7:0] errCnt_q; // Consecutive error count.
    logic [13:0] tick_q; // Millisecond prescaler.
    logic [15:0] msCnt_q; // Milliseconds without a good frame.
    logic tickNow; // One millisecond elapsed.
    assign tickNow = (tick_q == 14'(TICK - 1));

    // A good frame breaks the run; errors count up and saturate.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            errCnt_q <= 8'h00;
        end else if (okPulse) begin
            errCnt_q <= 8'h00;
        end else if (errPulse && errCnt_q != 8'hFF) begin
            errCnt_q <= errCnt_q + 8'h01; // RULE_08
        end
    end

    // Error flag is a level while the count is at or past the threshold.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            errHit <= 1'b0;
        end else begin
            errHit <= (threshold != 8'h00) && (errCnt_q >= threshold); // RULE_08
        end
    end

    // Free running prescaler giving the millisecond tick.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            tick_q <= 14'h0000;
        end else begin
            tick_q <= tickNow ? 14'h0000 : tick_q + 14'h0001;
        end
    end

    // Milliseconds since the last good frame; held at 16'hFFFF.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            msCnt_q <= 16'h0000;
            toutHit <= 1'b0;
        end else begin
            if (okPulse) begin
                msCnt_q <= 16'h0000;
            end else if (tickNow && msCnt_q != 16'hFFFF) begin
                msCnt_q <= msCnt_q + 16'h0001;
            end
            toutHit <= (timeoutMs != 16'h0000) && (msCnt_q >= timeoutMs); // RULE_09
        end
    end

    // The error flag follows the count reaching the threshold.
    commErrCount_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_08
        (threshold != 8'h00 && errCnt_q >= threshold && $stable(threshold)) |=> errHit)
        else $error("error count at threshold without alarm");
endmodule

// ---- src/home_check.sv ----
// Purpose: Checks the sensor_input_a input and timing output while the home sensor is active.
// Assumes: All inputs are synchronous to core_clk.
// Notes: The verdict is taken when the home sensor drops during home seeking.
module home_check (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic seeking,
    input wire logic homeSensorInput,
    input wire logic sensorInputA,
    input wire logic stepTimingOutput,
    input wire logic slitEn,
    input wire logic timEn,
    output logic fault
);
    import motor_alarm_pkg::*;
    logic homePrev_q; // Home sensor one cycle ago.
    logic seen_q; // An enabled qualifier was seen in this home window.
    logic hit; // Enabled qualifier active together with the home sensor.
    assign hit = homeSensorInput && ((slitEn && sensorInputA) || (timEn && stepTimingOutput));

    // Track qualifiers inside each home sensor window.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            homePrev_q <= 1'b0;
            seen_q <= 1'b0;
        end else begin
            homePrev_q <= homeSensorInput;
            if (!seeking || (!homePrev_q && homeSensorInput)) begin
                seen_q <= hit;
            end else if (hit) begin
                seen_q <= 1'b1; // RULE_16
            end
        end
    end

    // A window that closes with no qualifier, while a check is enabled, is a fault pulse.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            fault <= 1'b0;
        end else begin
            fault <= seeking && homePrev_q && !homeSensorInput && !seen_q
                && (slitEn || timEn); // RULE_17
        end
    end

    // With both checks disabled no fault may come.
    homeDisabled_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_16
        (!slitEn && !timEn) |=> !fault)
        else $error("home check fault with both checks disabled");
endmodule

// ---- src/motor_alarm_detector.sv ----
// Purpose: Alarm detection, latching, excitation and brake control of a stepping driver.
// Assumes: Status inputs are synchronous to core_clk; reset stands for a power cycle.
// Notes: Registers sit on an Avalon-MM slave answering one cycle after a request.
// Operation
// RULE_01: Positioning start at zero speed raises alarm.
// RULE_02: Push-motion speed above limit raises alarm.
// RULE_03: Mixed directions or five links raise alarm.
// RULE_04: Resolution out of range: gear alarm, latched.
// RULE_05: Resolution inconsistent with wrap range: alarm.
// RULE_06: Disconnected network master while running: alarm.
// RULE_07: Out-of-range rate switch raises alarm.
// RULE_08: Consecutive link errors reaching threshold alarm.
// RULE_09: Link timeout without communication raises alarm.
// RULE_10: Network converter alarm raises alarm.
// RULE_11: Excitation-off alarms cut motor current.
// RULE_12: Excitation-off alarms engage fitted brake.
// RULE_13: Excitation-on alarms keep motor current.
// RULE_14: Falling alarm-clear input clears resettable alarms.
// RULE_15: Rate switch alarm clears only on power.
// RULE_16: Home seeking needs sensor_input_a or timing, selectable.
// RULE_17: Neither seen during home seeking: alarm.
// RULE_18: Active alarm code latched until cleared.
`include "motor_alarm_regs.svh"
module motor_alarm_detector #(
    parameter int MS_CYCLES = `TICK_CYCLES
) (
    input wire logic core_clk,
    input wire logic reset,
    input wire logic [4:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic alarmClearInput,
    input wire logic sensorInputA,
    input wire logic stepTimingOutput,
    input wire logic homeSensorInput,
    input wire logic homeSeeking,
    input wire logic [3:0] rateSelectSwitch,
    input wire logic motorOperating,
    input wire logic netMasterDisconnected,
    input wire logic netConverterAlarm,
    input wire logic commErrorPulse,
    input wire logic commGoodPulse,
    input wire logic brakeFitted,
    output logic motorExcite,
    output logic brakeEngage,
    output logic alarmOut,
    output motor_alarm_pkg::alarm_code_t alarmCode,
    output logic irq
);
    import motor_alarm_pkg::*;

    // Merge write data into a register under the byte enables.
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                          input logic [3:0] be);
        logic [31:0] m;
        m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
        return (old & ~m) | (wd & m);
    endfunction

    // Mask of the first n linked entries, capped at eight.
    function automatic logic [7:0] linkMask(input logic [3:0] n);
        logic [7:0] m;
        m = (n >= 4'h8) ? 8'hFF : 8'((9'h001 << n) - 9'h001);
        return m;
    endfunction

    // Code of one alarm index.
    function automatic alarm_code_t codeOf(input int idx);
        alarm_code_t c;
        c = `CODE_NONE;
        case (idx)
            A_GEAR: c = `CODE_GEAR;
            A_WRAP: c = `CODE_WRAP;
            A_SWITCH: c = `CODE_SWITCH;
            A_OPDATA: c = `CODE_OPDATA;
            A_NETBUS: c = `CODE_NETBUS;
            A_COMMERR: c = `CODE_COMMERR;
            A_TIMEOUT: c = `CODE_TIMEOUT;
            A_NETCONV: c = `CODE_NETCONV;
            A_HOME: c = `CODE_HOME;
            default: c = `CODE_NONE;
        endcase
        return c;
    endfunction

    logic [15:0] speed_q; // Operating speed in r/min.
    logic [15:0] ctrl_q; // Push flag, link count and link directions.
    logic [15:0] res_q; // Resolution in pulses per revolution.
    logic [16:0] wrap_q; // Wrap range and wrap enable.
    logic [25:0] cfg_q; // Link threshold, timeout and home check enables.
    alarm_vec_t status_q; // Sticky alarm events.
    alarm_vec_t mask_q; // Interrupt enables.
    alarm_vec_t pend_q; // Alarms now pending.
    alarm_vec_t raise; // Alarm conditions this cycle.
    alarm_vec_t pend_d; // Next pending set.
    alarm_vec_t stClr; // Status bits cleared by software.
    logic clrPrev_q; // Alarm-clear input one cycle ago.
    logic clrFall; // Falling edge of the alarm-clear input.
    logic busTake; // Request accepted this cycle.
    logic wrTake; // Write accepted this cycle.
    logic startWr; // Start bit written this cycle.
    logic [31:0] wctl; // Merged control word of a write.
    logic pushMode; // Start request is a push-motion.
    logic [3:0] linkCnt; // Number of linked entries.
    logic [7:0] linkSel; // Directions of the linked entries.
    logic opBad; // Operation data fault on start.
    logic commErr; // Consecutive link error flag.
    logic commTout; // Link timeout flag.
    logic homeFault; // Home sensor qualifier fault.
    logic pwrAlarm; // An excitation-off alarm is pending.
    alarm_code_t code_d; // Highest priority pending code.

    assign busTake = (read || write) && !waitrequest;
    assign wrTake = busTake && write;
    assign clrFall = clrPrev_q && !alarmClearInput;
    assign wctl = merge({16'h0000, ctrl_q}, writedata, byteenable);
    assign startWr = wrTake && (address == `OFF_OP_CTRL) && wctl[`CTRL_START_BIT];
    assign pushMode = wctl[`CTRL_PUSH_BIT];
    assign linkCnt = wctl[`CTRL_CNT_LSB +: 4];
    assign linkSel = wctl[`CTRL_DIR_LSB +: 8] & linkMask(linkCnt);
    assign pwrAlarm = |(pend_q & alarm_vec_t'(`PWR_ONLY_MASK));

    // Operation data check made when a start is written.
    always_comb begin
        opBad = 1'b0;
        if (!pushMode && speed_q == `SPEED_ZERO) begin
            opBad = 1'b1; // RULE_01
        end
        if (pushMode && speed_q > `PUSH_SPEED_MAX) begin
            opBad = 1'b1; // RULE_02
        end
        if (linkCnt >= `LINK_MAX || (linkSel != 8'h00 && linkSel != linkMask(linkCnt))) begin
            opBad = 1'b1; // RULE_03
        end
    end

    // Link error counter and timeout.
    comm_watch #(.TICK(MS_CYCLES)) uComm (
        .core_clk(core_clk),
        .reset(reset),
        .errPulse(commErrorPulse),
        .okPulse(commGoodPulse),
        .threshold(cfg_q[7:0]),
        .timeoutMs(cfg_q[`CFG_TOUT_LSB +: 16]),
        .errHit(commErr),
        .toutHit(commTout)
    );

    // Sensor_input_a and timing check during home seeking.
    home_check uHome (
        .core_clk(core_clk),
        .reset(reset),
        .seeking(homeSeeking),
        .homeSensorInput(homeSensorInput),
        .sensorInputA(sensorInputA),
        .stepTimingOutput(stepTimingOutput),
        .slitEn(cfg_q[`CFG_SENSOR_INPUT_A_EN_BIT]),
        .timEn(cfg_q[`CFG_TIM_EN_BIT]),
        .fault(homeFault)
    );

    // Gather the alarm conditions of this cycle.
    always_comb begin
        raise = '0;
        raise[A_GEAR] = (res_q < `RES_MIN) || (res_q > `RES_MAX); // RULE_04
        raise[A_WRAP] = wrap_q[`WRAP_EN_BIT] && (wrap_q[15:0] < res_q); // RULE_05
        raise[A_SWITCH] = rateSelectSwitch > `RATE_MAX; // RULE_07
        raise[A_OPDATA] = startWr && opBad;
        raise[A_NETBUS] = motorOperating && netMasterDisconnected; // RULE_06
        raise[A_COMMERR] = commErr; // RULE_08
        raise[A_TIMEOUT] = commTout; // RULE_09
        raise[A_NETCONV] = netConverterAlarm; // RULE_10
        raise[A_HOME] = homeFault; // RULE_17
    end

    // Falling clear edge drops resettable alarms; a new raise wins over the clear.
    always_comb begin
        pend_d = pend_q;
        if (clrFall) begin
            pend_d = pend_q & alarm_vec_t'(`PWR_ONLY_MASK); // RULE_14 RULE_15
        end
        pend_d = pend_d | raise;
    end

    // Pending alarms; only reset removes the power cycle class.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            pend_q <= '0;
            clrPrev_q <= 1'b0;
        end else begin
            pend_q <= pend_d; // RULE_04 RULE_15
            clrPrev_q <= alarmClearInput;
        end
    end

    // Priority encode the pending set; power cycle class first.
    always_comb begin
        code_d = `CODE_NONE;
        for (int i = 8; i >= 0; i--) begin
            if (pend_d[i]) begin
                code_d = codeOf(i);
            end
        end
    end

    // Alarm code and alarm output stand while an alarm is pending.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            alarmCode <= `CODE_NONE;
            alarmOut <= 1'b0;
        end else begin
            alarmCode <= code_d; // RULE_18
            alarmOut <= |pend_d;
        end
    end

    // Excitation and brake follow the pending excitation-off class.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            motorExcite <= 1'b1;
            brakeEngage <= 1'b0;
        end else begin
            motorExcite <= !pwrAlarm; // RULE_11 RULE_13
            brakeEngage <= pwrAlarm && brakeFitted; // RULE_12
        end
    end

    // Software write-one-to-clear on the status register.
    assign stClr = (wrTake && address == `OFF_STATUS) ?
        alarm_vec_t'(merge('0, writedata, byteenable)) : '0;

    // Sticky status: each newly pending alarm sets its bit; a set beats a clear.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            status_q <= '0;
        end else begin
            status_q <= (status_q & ~stClr) | (raise & ~pend_q);
        end
    end

    // Level interrupt from unmasked status bits.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            irq <= 1'b0;
        end else begin
            irq <= |(status_q & mask_q);
        end
    end

    // Writable registers.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            speed_q <= 16'h0000;
            ctrl_q <= 16'h0000;
            res_q <= `RST_RESOLUTION;
            wrap_q <= `RST_WRAP;
            cfg_q <= `RST_COMM_CFG;
            mask_q <= '0;
        end else if (wrTake) begin
            unique case (address)
                `OFF_OP_SPEED: speed_q <= 16'(merge({16'h0000, speed_q}, writedata, byteenable));
                `OFF_OP_CTRL: ctrl_q <= wctl[15:0] & 16'hFFFD;
                `OFF_RESOLUTION: res_q <= 16'(merge({16'h0000, res_q}, writedata, byteenable));
                `OFF_WRAP: wrap_q <= 17'(merge({15'h0000, wrap_q}, writedata, byteenable));
                `OFF_COMM_CFG: cfg_q <= 26'(merge({6'h00, cfg_q}, writedata, byteenable));
                `OFF_MASK: mask_q <= alarm_vec_t'(merge('0, writedata, byteenable));
                default: ;
            endcase
        end
    end

    // One wait cycle per request; read data are set during it.
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            waitrequest <= 1'b1;
            readdata <= 32'h0000_0000;
        end else begin
            waitrequest <= !((read || write) && waitrequest);
            if (read && waitrequest) begin
                unique case (address)
                    `OFF_OP_SPEED: readdata <= {16'h0000, speed_q};
                    `OFF_OP_CTRL: readdata <= {16'h0000, ctrl_q};
                    `OFF_RESOLUTION: readdata <= {16'h0000, res_q};
                    `OFF_WRAP: readdata <= {15'h0000, wrap_q};
                    `OFF_COMM_CFG: readdata <= {6'h00, cfg_q};
                    `OFF_STATUS: readdata <= {23'h00_0000, status_q};
                    `OFF_MASK: readdata <= {23'h00_0000, mask_q};
                    `OFF_ALARM: readdata <= {21'h00_0000, brakeEngage, motorExcite,
                                             alarmOut, alarmCode};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Zero speed positioning start raises the operation data alarm.
    zeroSpeed_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_01
        (startWr && !pushMode && speed_q == `SPEED_ZERO) |=> pend_q[A_OPDATA])
        else $error("zero speed start without alarm");

    // Too fast push-motion start raises the operation data alarm.
    pushSpeed_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_02
        (startWr && pushMode && speed_q > `PUSH_SPEED_MAX) |=> pend_q[A_OPDATA])
        else $error("fast push start without alarm");

    // Five or more links raise the operation data alarm.
    linkCount_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_03
        (startWr && linkCnt >= `LINK_MAX) |=> pend_q[A_OPDATA])
        else $error("long link chain without alarm");

    // A gear alarm stays until reset, whatever the clear input does.
    gearHold_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_04
        pend_q[A_GEAR] |=> pend_q[A_GEAR] [*3])
        else $error("gear alarm left without power cycle");

    // Network bus fault while running is caught next cycle.
    netBus_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_06
        (motorOperating && netMasterDisconnected) |=> alarmOut && pend_q[A_NETBUS])
        else $error("network bus fault missed");

    // Rate switch fault is raised and survives a clear edge.
    rateSwitch_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_15
        (rateSelectSwitch > `RATE_MAX) |=> pend_q[A_SWITCH] ##1 pend_q[A_SWITCH])
        else $error("rate switch alarm dropped");

    // Excitation is off one cycle after an excitation-off alarm, with the brake if fitted.
    exciteOff_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_11
        pwrAlarm |=> !motorExcite && (brakeEngage == $past(brakeFitted)))
        else $error("excitation not cut");

    // Excitation-on alarms leave current on.
    exciteOn_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_13
        (!pwrAlarm && pend_q != '0) |=> motorExcite && !brakeEngage)
        else $error("excitation dropped on holding alarm");

    // A clear edge with no new cause removes a resettable alarm.
    clearEdge_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_14
        (clrFall && !raise[A_NETCONV]) |=> !pend_q[A_NETCONV])
        else $error("resettable alarm not cleared");

    // The code shows the operation data alarm once it is the only pending alarm.
    codeLatch_a: assert property (@(posedge core_clk) disable iff (reset) // RULE_18
        pend_q[A_OPDATA] && !pwrAlarm && pend_q[A_NETBUS] == 1'b0 ##0 $stable(pend_q)
        |-> alarmCode == `CODE_OPDATA || pend_q[8:5] != '0)
        else $error("latched code wrong");

    // The bus answers exactly one cycle after a request is raised.
    busAnswer_a: assert property (@(posedge core_clk) disable iff (reset)
        ((read || write) && waitrequest) |=> !waitrequest)
        else $error("bus answer late");

    startCover_c: cover property (@(posedge core_clk) disable iff (reset) startWr && opBad);
    clearCover_c: cover property (@(posedge core_clk) disable iff (reset)
        clrFall && pend_q != '0);
    gearCover_c: cover property (@(posedge core_clk) disable iff (reset) pend_q[A_GEAR]);
endmodule

// ---- src/motor_alarm_pkg.sv ----
// Purpose: Shared types of the alarm detector.
// Assumes: Nothing beyond the register header.
// Notes: Alarm vector bit order is also the code priority order.
package motor_alarm_pkg;
    // One bit per alarm source.
    typedef logic [8:0] alarm_vec_t;
    // Latched alarm code.
    typedef logic [7:0] alarm_code_t;
    // Alarm indexes.
    typedef enum logic [3:0] {
        A_GEAR, A_WRAP, A_SWITCH, A_OPDATA, A_NETBUS,
        A_COMMERR, A_TIMEOUT, A_NETCONV, A_HOME
    } alarm_idx_t;
endpackage

// ---- src/motor_alarm_regs.svh ----
// Purpose: Register offsets, field positions, reset values and counts of the alarm detector.
// Assumes: Byte addresses on a 32-bit Avalon-MM slave, 10 MHz core clock.
// Notes: Definitions only; included by bare name.
`ifndef MOTOR_ALARM_REGS_SVH
`define MOTOR_ALARM_REGS_SVH
// Register byte offsets.
`define OFF_OP_SPEED 5'h00
`define OFF_OP_CTRL 5'h04
`define OFF_RESOLUTION 5'h08
`define OFF_WRAP 5'h0C
`define OFF_COMM_CFG 5'h10
`define OFF_STATUS 5'h14
`define OFF_MASK 5'h18
`define OFF_ALARM 5'h1C
// Field positions.
`define CTRL_PUSH_BIT 0
`define CTRL_START_BIT 1
`define CTRL_CNT_LSB 4
`define CTRL_DIR_LSB 8
`define WRAP_EN_BIT 16
`define CFG_TOUT_LSB 8
`define CFG_SENSOR_INPUT_A_EN_BIT 24
`define CFG_TIM_EN_BIT 25
`define ALM_ACTIVE_BIT 8
`define ALM_EXCITE_BIT 9
`define ALM_BRAKE_BIT 10
// Reset values.
`define RST_RESOLUTION 16'h03E8
`define RST_WRAP 17'h0_0000
`define RST_COMM_CFG 26'h300_0003
// Limits.
`define SPEED_ZERO 16'h0000
`define PUSH_SPEED_MAX 16'h01F4
`define RES_MIN 16'h0064
`define RES_MAX 16'h2710
`define LINK_MAX 4'h5
`define RATE_MAX 4'h4
// Alarm codes.
`define CODE_NONE 8'h00
`define CODE_GEAR 8'h71
`define CODE_WRAP 8'h72
`define CODE_SWITCH 8'h83
`define CODE_OPDATA 8'h70
`define CODE_NETBUS 8'h81
`define CODE_COMMERR 8'h84
`define CODE_TIMEOUT 8'h85
`define CODE_NETCONV 8'h8E
`define CODE_HOME 8'h64
// Alarms cleared only by a power cycle, excitation off.
`define PWR_ONLY_MASK 9'h007
// Timeout tick: one millisecond at a 100 ns clock period.
`define TICK_NS 1000000
`define CLK_NS 100
`define TICK_CYCLES (`TICK_NS / `CLK_NS)
`endif

// ---- tb/master_model.sv ----
// Purpose: Master controller model: alarm clear input and link frames.
// Assumes: It drives just after a rising edge.
// Notes: The bench calls its tasks.
module master_model (
    input wire logic core_clk,
    output logic alarmClearInput,
    output logic commErrorPulse,
    output logic commGoodPulse
);
    timeunit 1ns;
    timeprecision 1ns;
    // All lines idle low from time zero.
    initial begin
        alarmClearInput = 1'b0;
        commErrorPulse = 1'b0;
        commGoodPulse = 1'b0;
    end
    // A clear is one active cycle, then the falling edge.
    task automatic clearAlarm();
        @(posedge core_clk) alarmClearInput <= 1'b1;
        @(posedge core_clk) alarmClearInput <= 1'b0;
    endtask
    // Sends n bad frames back to back, then one good frame that ends the run.
    task automatic badFrames(input int n);
        repeat (n) @(posedge core_clk) commErrorPulse <= 1'b1;
        @(posedge core_clk) begin
            commErrorPulse <= 1'b0;
            commGoodPulse <= 1'b1;
        end
        @(posedge core_clk) commGoodPulse <= 1'b0;
    endtask
endmodule

// ---- tb/tb_motor_alarm_detector.sv ----
// Purpose: Self-checking bench of the alarm detector.
// Assumes: One wait cycle per bus access.
// Notes: Reads queue their expected words; a monitor compares them.
`include "motor_alarm_regs.svh"
`define CHK(a, b) begin nTests++; if ((a) !== (b)) begin failCount++; \
    $display("unexpected at %0t: %h vs %h", $time, a, b); end end
module tb_motor_alarm_detector;
    timeunit 1ns;
    timeprecision 1ns;
    import motor_alarm_pkg::*;
    logic core_clk = 1'b0, reset = 1'b1, read = 1'b0, write = 1'b0, irq;
    logic [4:0] address = 5'h00;
    logic [31:0] writedata = 32'h0000_0000, readdata, v, ex;
    logic waitrequest, motorExcite, brakeEngage, alarmOut;
    logic motorOperating = 1'b0, netMasterDisconnected = 1'b0;
    logic netConverterAlarm = 1'b0, brakeFitted = 1'b0, homeSeeking = 1'b0;
    logic sensorInputA = 1'b0, stepTimingOutput = 1'b0, homeSensorInput = 1'b0;
    logic alarmClearInput, commErrorPulse, commGoodPulse;
    logic [3:0] rateSelectSwitch = 4'h0;
    alarm_code_t alarmCode;
    logic [31:0] expQ[$];
    logic [31:0] cases[4] = '{32'h0000_0002, 32'h01F5_0003, 32'h0064_0052, 32'h0064_0122};
    int failCount = 0, nTests = 0, cycles = 0;
    always #50 core_clk = ~core_clk;
    motor_alarm_detector #(.MS_CYCLES(10)) uut (.core_clk, .reset, .address, .read, .write,
        .writedata, .byteenable(4'hF), .readdata, .waitrequest, .alarmClearInput,
        .sensorInputA, .stepTimingOutput, .homeSensorInput,
        .homeSeeking, .rateSelectSwitch, .motorOperating, .netMasterDisconnected,
        .netConverterAlarm, .commErrorPulse, .commGoodPulse, .brakeFitted, .motorExcite,
        .brakeEngage, .alarmOut, .alarmCode, .irq);
    master_model m (.core_clk, .alarmClearInput, .commErrorPulse, .commGoodPulse);
    // Compares each read word as it is taken, and bounds the run.
    always @(posedge core_clk) begin
        if (read && !waitrequest) begin
            ex = expQ.pop_front();
            `CHK(readdata, ex)
        end
        cycles++;
        if (cycles > 20000) begin
            failCount++;
            closeOut();
        end
    end
    // One Avalon access; settles causes first, holds until waitrequest is low.
    task automatic bus(input logic [4:0] a, input logic w, input logic [31:0] d);
        repeat (3) @(posedge core_clk);
        address <= a;
        writedata <= d;
        write <= w;
        read <= !w;
        @(posedge core_clk);
        while (waitrequest) @(posedge core_clk);
        read <= 1'b0;
        write <= 1'b0;
    endtask
    // Reads a register after noting the expected word.
    task automatic rd(input logic [4:0] a, input logic [31:0] e);
        expQ.push_back(e);
        bus(a, 1'b0, 32'h0000_0000);
    endtask
    // Two-cycle home window with the given sensor_input_a and timing levels, then an alarm read.
    task automatic homeWin(input logic [1:0] q, input logic [31:0] e);
        {sensorInputA, stepTimingOutput} <= q;
        homeSensorInput <= 1'b1;
        repeat (2) @(posedge core_clk);
        homeSensorInput <= 1'b0;
        rd(`OFF_ALARM, e);
    endtask
    // Prints the verdict and ends the run.
    task automatic closeOut();
        if (failCount == 0 && nTests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    initial begin
        void'($urandom(17));
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rateSelectSwitch <= 4'($urandom % 5);
        v = 32'h0000_0064 + ($urandom % 32'h0000_26AD);
        bus(`OFF_RESOLUTION, 1'b1, v);
        rd(`OFF_ALARM, 32'h0000_0200);
        bus(`OFF_MASK, 1'b1, 32'h0000_01FF);
        motorOperating <= 1'b1;
        netMasterDisconnected <= 1'b1;
        rd(`OFF_ALARM, 32'h0000_0381);
        rd(`OFF_STATUS, 32'h0000_0010);
        `CHK(irq, 1'b1)
        netMasterDisconnected <= 1'b0;
        m.clearAlarm();
        rd(`OFF_ALARM, 32'h0000_0200);
        bus(`OFF_STATUS, 1'b1, 32'h0000_01FF);
        rd(`OFF_STATUS, 32'h0000_0000);
        `CHK(irq, 1'b0)
        netConverterAlarm <= 1'b1;
        rd(`OFF_ALARM, 32'h0000_038E);
        netConverterAlarm <= 1'b0;
        m.clearAlarm();
        homeSeeking <= 1'b1;
        homeWin(2'($urandom % 3 + 1), 32'h0000_0200);
        homeWin(2'b00, 32'h0000_0364);
        m.clearAlarm();
        // Zero speed, fast push, five links, mixed directions.
        foreach (cases[i]) begin
            bus(`OFF_OP_SPEED, 1'b1, {16'h0000, cases[i][31:16]});
            bus(`OFF_OP_CTRL, 1'b1, {16'h0000, cases[i][15:0]});
            rd(`OFF_ALARM, 32'h0000_0370);
            m.clearAlarm();
        end
        m.badFrames(3);
        rd(`OFF_ALARM, 32'h0000_0384);
        m.clearAlarm();
        rd(`OFF_ALARM, 32'h0000_0200);
        bus(`OFF_COMM_CFG, 1'b1, 32'h0300_0103);
        rd(`OFF_ALARM, 32'h0000_0385);
        brakeFitted <= 1'b1;
        bus(`OFF_WRAP, 1'b1, 32'h0001_0000);
        rd(`OFF_ALARM, 32'h0000_0572);
        bus(`OFF_RESOLUTION, 1'b1, 32'h0000_0063);
        rateSelectSwitch <= 4'h5;
        rd(`OFF_ALARM, 32'h0000_0571);
        m.clearAlarm();
        rd(`OFF_ALARM, 32'h0000_0571);
        reset <= 1'b1;
        rateSelectSwitch <= 4'($urandom % 5);
        repeat (3) @(posedge core_clk);
        reset <= 1'b0;
        rd(`OFF_ALARM, 32'h0000_0200);
        closeOut();
    end
endmodule
